/* src/dpc_defs.svh */
// Constants for the pin-level command decoder and data-lane control.
`ifndef DPC_DEFS_SVH
`define DPC_DEFS_SVH

// Command codes, ordered {select, row strobe, column strobe, write enable}.
`define DPC_CMD_ACT 4'h3
`define DPC_CMD_PRE 4'h2
`define DPC_CMD_RD  4'h5
`define DPC_CMD_WR  4'h4

// Address fields.
`define DPC_A10_BIT 10

// Burst length in data beats; latency and precharge counts in link clock rises.
`define DPC_BURST_LEN 4
`define DPC_CAS_LAT   2
`define DPC_PRE_EDGES 2

// Counter widths and reset values.
`define DPC_BEAT_W    4
`define DPC_LAT_W     3
`define DPC_PRE_W     3
`define DPC_CKE_RST   1'h1

`endif

/* src/dpc_pkg.sv */
// Types shared by the command decoder and its memory.
package dpc_pkg;
	typedef logic [1:0] dpc_bank_t;
	typedef logic [12:0] dpc_addr_t;
	typedef logic [15:0] dpc_data_t;
	typedef enum logic [1:0] {ST_IDLE, ST_RD_WAIT, ST_RD_BURST, ST_WR_BURST} dpc_state_e;
endpackage

/* src/dpc_mem_if.sv */
// Interface between the decoder and its storage array.
`timescale 1ns/1ps
interface dpc_mem_if #(parameter int AW = 7) ();
	logic                wr_en;
	logic [1:0]          wr_be;
	logic [AW-1:0]       wr_addr;
	dpc_pkg::dpc_data_t  wr_data;
	logic                rd_en;
	logic [AW-1:0]       rd_addr;
	dpc_pkg::dpc_data_t  rd_data;
	modport ctrl (output wr_en, wr_be, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
	modport mem (input wr_en, wr_be, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface

/* src/dpc_sync.sv */
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module dpc_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Pins in, synchronised levels out.
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s1_q;

	// The first stage feeds only the second, so metastability never reaches logic.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			dout <= '0;
		end else begin
			s1_q <= din;
			dout <= s1_q;
		end
	end

	chk_sync_delay: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n, 2) |-> dout == $past(din, 2)) else $error("sync delay not two cycles");
endmodule

/* src/dpc_mem.sv */
// Byte-writable storage array with registered read data.
`timescale 1ns/1ps
module dpc_mem #(
	parameter int AW = 7
) (
	// Clock.
	input  wire logic clk,
	// Access port.
	dpc_mem_if.mem    port
);
	import dpc_pkg::*;

	dpc_data_t store [2**AW];

	// Each byte lane is written only when its enable is set.
	always_ff @(posedge clk) begin
		for (int l = 0; l < 2; l++) begin
			if (port.wr_en && port.wr_be[l]) begin
				store[port.wr_addr][8*l +: 8] <= port.wr_data[8*l +: 8];
			end
		end
		if (port.rd_en) begin
			port.rd_data <= store[port.rd_addr];
		end
	end

	chk_mem_readback: assert property (@(posedge clk)
		(port.wr_en && port.wr_be == 2'h3) ##1 (port.rd_en && port.rd_addr == $past(port.wr_addr))
		|=> port.rd_data == $past(port.wr_data, 2)) else $error("read does not return write");
endmodule

/* src/dpc_top.sv */
// Pin-level command decoder, bank state and double-edge data lanes of a DRAM.
`timescale 1ns/1ps
`include "dpc_defs.svh"
module dpc_top #(
	parameter int BURST_LEN = `DPC_BURST_LEN,
	parameter int CAS_LAT   = `DPC_CAS_LAT,
	parameter int PRE_EDGES = `DPC_PRE_EDGES,
	parameter int ROW_AW    = 2,
	parameter int COL_AW    = 3
) (
	// Clock and reset.
	input  wire logic               mclk,
	input  wire logic               rst_n,
	// Link clock and command pins.
	input  wire logic               ck,
	input  wire logic               cke,
	input  wire logic               cs_n,
	input  wire logic               ras_n,
	input  wire logic               cas_n,
	input  wire logic               we_n,
	input  wire dpc_pkg::dpc_bank_t ba,
	input  wire dpc_pkg::dpc_addr_t addr,
	// Data lines.
	input  wire dpc_pkg::dpc_data_t dq_in,
	output dpc_pkg::dpc_data_t      dq_out,
	output logic                    dq_oe,
	// Byte-lane strobes and masks.
	input  wire logic               lower_byte_strobe_in,
	output logic                    lower_byte_strobe_out,
	output logic                    lower_byte_strobe_oe,
	input  wire logic               upper_byte_strobe_in,
	output logic                    upper_byte_strobe_out,
	output logic                    upper_byte_strobe_oe,
	input  wire logic               lower_byte_mask,
	input  wire logic               upper_byte_mask,
	// Status.
	output logic [3:0]              bank_active
);
	import dpc_pkg::*;

	localparam int SW  = 41;
	localparam int MAW = 2 + ROW_AW + COL_AW;
	localparam int BW  = `DPC_BEAT_W;
	localparam int LW  = `DPC_LAT_W;
	localparam int PW  = `DPC_PRE_W;
	localparam logic [BW-1:0]     BL_C   = BW'(BURST_LEN);
	localparam logic [LW-1:0]     CL_C   = LW'(CAS_LAT);
	localparam logic [PW-1:0]     PRE_C  = PW'(PRE_EDGES);
	localparam logic [COL_AW-1:0] WRAP_C = COL_AW'(BURST_LEN - 1);

	// Synchronised pins; ck_q and str_q hold one more stage for edge detection.
	logic            ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s;
	dpc_bank_t       ba_s;
	dpc_addr_t       addr_s;
	dpc_data_t       dq_s;
	logic [1:0]      str_s, msk_s, str_q;
	logic            ck_q;

	// Control state.
	dpc_state_e      state_q, state_d;
	logic [3:0]      bank_open_q, bank_open_d;
	logic [PW-1:0]   pre_cnt_q [4];
	logic [PW-1:0]   pre_cnt_d [4];
	logic [ROW_AW-1:0] row_q [4];
	logic [ROW_AW-1:0] row_d [4];
	dpc_bank_t       cur_bank_q, cur_bank_d;
	logic [COL_AW-1:0] col_q, col_d, col_wrap;
	logic            ap_q, ap_d, clk_en_q, clk_en_d;
	logic [LW-1:0]   lat_q, lat_d;
	logic [BW-1:0]   beat_q, beat_d;
	logic            rd_en, rd_pend_q, ap_fire;

	// Read output state.
	dpc_data_t       dq_out_q, dq_out_d;
	logic            dq_oe_q, dq_oe_d, dqs_q, dqs_d;

	// Decode and write lanes.
	logic            ck_rise, ck_edge, cmd_edge, act_hit, pre_hit, rd_hit, wr_hit;
	logic [3:0]      cmd_code;
	logic [1:0]      got_v, wmsk_v;
	logic [15:0]     wdata_v;
	logic            commit;

	dpc_mem_if #(.AW(MAW)) mif ();

	dpc_sync #(.W(SW)) u_sync (
		.clk  (mclk),
		.rst_n(rst_n),
		.din  ({ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq_in,
			upper_byte_strobe_in, lower_byte_strobe_in, upper_byte_mask, lower_byte_mask}),
		.dout ({ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, addr_s, dq_s,
			str_s, msk_s})
	);

	dpc_mem #(.AW(MAW)) u_mem (
		.clk (mclk),
		.port(mif.mem)
	);

	// Link clock edges; every pin passes the same two stages, so they stay aligned.
	assign ck_rise  = ck_s & ~ck_q;
	assign ck_edge  = ck_s ^ ck_q;
	assign cmd_edge = ck_rise & clk_en_q;
	assign cmd_code = {cs_n_s, ras_n_s, cas_n_s, we_n_s};

	// Select is part of the code, so a high select never matches a command.
	assign act_hit = cmd_edge && cmd_code == `DPC_CMD_ACT;
	assign pre_hit = cmd_edge && cmd_code == `DPC_CMD_PRE;
	assign rd_hit  = cmd_edge && cmd_code == `DPC_CMD_RD;
	assign wr_hit  = cmd_edge && cmd_code == `DPC_CMD_WR;

	// Bursts wrap inside an aligned block of burst length columns.
	assign col_wrap = (col_q & ~WRAP_C) | ((col_q + COL_AW'(beat_q)) & WRAP_C);

	// Write beats: each lane latches its byte and mask on either edge of its own strobe.
	for (genvar l = 0; l < 2; l++) begin : g_lane
		logic       got_q, got_d, msk_q, msk_d;
		logic [7:0] byte_q, byte_d;
		always_comb begin
			got_d  = got_q;
			msk_d  = msk_q;
			byte_d = byte_q;
			// A new strobe edge in the commit cycle wins over the clear, so no beat is lost.
			if (state_q != ST_WR_BURST) begin
				got_d = 1'b0;
			end else if ((str_s[l] ^ str_q[l]) && (!got_q || commit)) begin
				got_d  = 1'b1;
				byte_d = dq_s[8*l +: 8];
				msk_d  = msk_s[l];
			end else if (commit) begin
				got_d = 1'b0;
			end
		end
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				got_q  <= 1'b0;
				msk_q  <= 1'b0;
				byte_q <= 8'h00;
			end else begin
				got_q  <= got_d;
				msk_q  <= msk_d;
				byte_q <= byte_d;
			end
		end
		assign got_v[l]         = got_q;
		assign wmsk_v[l]        = msk_q;
		assign wdata_v[8*l +: 8] = byte_q;
	end

	// A beat is stored once both lanes have it; a high mask drops its byte.
	assign commit       = state_q == ST_WR_BURST && got_v == 2'h3;
	assign mif.wr_en    = commit;
	assign mif.wr_be    = ~wmsk_v;
	assign mif.wr_data  = wdata_v;
	assign mif.wr_addr  = {cur_bank_q, row_q[cur_bank_q], col_wrap};
	assign mif.rd_en    = rd_en;
	assign mif.rd_addr  = {cur_bank_q, row_q[cur_bank_q], col_wrap};

	// Command decode, bank timers and burst sequencing.
	always_comb begin
		state_d     = state_q;
		bank_open_d = bank_open_q;
		pre_cnt_d   = pre_cnt_q;
		row_d       = row_q;
		cur_bank_d  = cur_bank_q;
		col_d       = col_q;
		ap_d        = ap_q;
		lat_d       = lat_q;
		beat_d      = beat_q;
		clk_en_d    = clk_en_q;
		rd_en       = 1'b0;
		ap_fire     = 1'b0;
		if (ck_rise) begin
			clk_en_d = cke_s;
		end
		for (int b = 0; b < 4; b++) begin
			if (cmd_edge && pre_cnt_q[b] != '0) begin
				pre_cnt_d[b] = pre_cnt_q[b] - 1'b1;
				if (pre_cnt_q[b] == PW'(1)) begin
					bank_open_d[b] = 1'b0;
				end
			end
		end
		case (state_q)
			ST_RD_WAIT: begin
				if (cmd_edge) begin
					if (lat_q == LW'(1)) begin
						rd_en   = 1'b1;
						beat_d  = BW'(1);
						state_d = ST_RD_BURST;
					end else begin
						lat_d = lat_q - 1'b1;
					end
				end
			end
			ST_RD_BURST: begin
				if (ck_edge && clk_en_q) begin
					if (beat_q == BL_C) begin
						state_d = ST_IDLE;
						ap_fire = ap_q;
					end else begin
						rd_en  = 1'b1;
						beat_d = beat_q + 1'b1;
					end
				end
			end
			ST_WR_BURST: begin
				if (commit) begin
					beat_d = beat_q + 1'b1;
					if (beat_q == BL_C - 1'b1) begin
						state_d = ST_IDLE;
						ap_fire = ap_q;
					end
				end
			end
			default: begin
			end
		endcase
		if (ap_fire) begin
			pre_cnt_d[cur_bank_q] = PRE_C;
		end
		if (act_hit) begin
			bank_open_d[ba_s] = 1'b1;
			row_d[ba_s]       = addr_s[ROW_AW-1:0];
			pre_cnt_d[ba_s]   = '0;
		end
		if (pre_hit) begin
			pre_cnt_d[ba_s] = PRE_C;
		end
		if (rd_hit || wr_hit) begin
			cur_bank_d = ba_s;
			col_d      = addr_s[COL_AW-1:0];
			ap_d       = addr_s[`DPC_A10_BIT];
			beat_d     = '0;
			lat_d      = CL_C;
			state_d    = rd_hit ? ST_RD_WAIT : ST_WR_BURST;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q     <= ST_IDLE;
			bank_open_q <= 4'h0;
			pre_cnt_q   <= '{default: '0};
			row_q       <= '{default: '0};
			cur_bank_q  <= 2'h0;
			col_q       <= '0;
			ap_q        <= 1'b0;
			lat_q       <= '0;
			beat_q      <= '0;
			clk_en_q    <= `DPC_CKE_RST;
			ck_q        <= 1'b0;
			str_q       <= 2'h0;
			rd_pend_q   <= 1'b0;
		end else begin
			state_q     <= state_d;
			bank_open_q <= bank_open_d;
			pre_cnt_q   <= pre_cnt_d;
			row_q       <= row_d;
			cur_bank_q  <= cur_bank_d;
			col_q       <= col_d;
			ap_q        <= ap_d;
			lat_q       <= lat_d;
			beat_q      <= beat_d;
			clk_en_q    <= clk_en_d;
			ck_q        <= ck_s;
			str_q       <= str_s;
			rd_pend_q   <= rd_en;
		end
	end

	// Read data and strobe change in the same cycle, one cycle after the array read.
	always_comb begin
		dq_out_d = dq_out_q;
		dq_oe_d  = dq_oe_q;
		dqs_d    = dqs_q;
		if (rd_pend_q) begin
			dq_out_d = mif.rd_data;
			dqs_d    = ~dqs_q;
			dq_oe_d  = 1'b1;
		end
		if (state_q == ST_RD_BURST && state_d != ST_RD_BURST) begin
			dq_oe_d = 1'b0;
			dqs_d   = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dq_out_q <= 16'h0000;
			dq_oe_q  <= 1'b0;
			dqs_q    <= 1'b0;
		end else begin
			dq_out_q <= dq_out_d;
			dq_oe_q  <= dq_oe_d;
			dqs_q    <= dqs_d;
		end
	end

	// Both strobes share one flop so the lanes can never skew on reads.
	assign dq_out                = dq_out_q;
	assign dq_oe                 = dq_oe_q;
	assign lower_byte_strobe_out = dqs_q;
	assign upper_byte_strobe_out = dqs_q;
	assign lower_byte_strobe_oe  = dq_oe_q;
	assign upper_byte_strobe_oe  = dq_oe_q;
	assign bank_active           = bank_open_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	chk_cs_masks_cmd: assert property (
		cmd_edge && cs_n_s |-> !(act_hit || pre_hit || rd_hit || wr_hit))
		else $error("command decoded with select high");
	chk_cmd_on_rise: assert property (
		(act_hit || pre_hit || rd_hit || wr_hit) |-> ck_s && !ck_q)
		else $error("command taken off a clock rise");
	chk_act_opens: assert property (
		act_hit |=> bank_open_q[$past(ba_s)]) else $error("row open did not activate bank");
	chk_col_bank: assert property (
		(rd_hit || wr_hit) |=> cur_bank_q == $past(ba_s) && col_q == $past(addr_s[COL_AW-1:0]))
		else $error("column access took wrong bank or column");
	chk_rd_wr_dir: assert property (
		(rd_hit |=> state_q == ST_RD_WAIT) and (wr_hit |=> state_q == ST_WR_BURST))
		else $error("read and write swapped");
	chk_strobe_data: assert property (
		rd_pend_q |=> dq_oe_q && dqs_q != $past(dqs_q) && dq_out_q == $past(mif.rd_data))
		else $error("read strobe not aligned with data");
	chk_mask_drop: assert property (
		commit && wmsk_v[0] |-> !mif.wr_be[0] && mif.wr_be[1] == !wmsk_v[1])
		else $error("masked byte written");
	chk_write_beats: assert property (
		commit && beat_q == BL_C - 1'b1 && !(rd_hit || wr_hit) |=> state_q == ST_IDLE)
		else $error("write burst length wrong");
	chk_cke_freeze: assert property (
		!clk_en_q && $past(!clk_en_q) && $past(!clk_en_q, 2)
			|-> $stable(dqs_q) && $stable(dq_out_q) && $stable(beat_q)
			|| state_q == ST_WR_BURST)
		else $error("outputs moved while suspended");
	for (genvar b = 0; b < 4; b++) begin : g_chk
		chk_pre_closes: assert property (
			pre_hit && ba_s == 2'(b) && clk_en_q && cke_s ##1 !act_hit [*8] |-> ##[0:60] !bank_open_q[b])
			else $error("precharge did not idle bank");
	end

	cov_row_open: cover property (act_hit);
	cov_read_done: cover property (state_q == ST_RD_BURST ##1 state_q == ST_IDLE);
	cov_masked_beat: cover property (commit && wmsk_v != 2'h0);
	cov_suspended_read: cover property (!clk_en_q && state_q == ST_RD_BURST);
endmodule

/* bench/dpc_ctrl_model.sv */
// Behavioural memory controller: link clock, commands and write bursts.
`timescale 1ns/1ps
module dpc_ctrl_model (
	// System clock that paces the link.
	input  wire logic               mclk,
	// Pins toward the device.
	output logic                    ck,
	output logic                    cke,
	output logic                    cs_n,
	output logic                    ras_n,
	output logic                    cas_n,
	output logic                    we_n,
	output dpc_pkg::dpc_bank_t      ba,
	output dpc_pkg::dpc_addr_t      addr,
	output logic                    lower_byte_mask,
	output logic                    upper_byte_mask,
	// Shared lines as seen on the board.
	output dpc_pkg::dpc_data_t      dq_w,
	output logic                    lo_stb_w,
	output logic                    up_stb_w,
	// Device side of the shared lines.
	input  wire dpc_pkg::dpc_data_t dq_out,
	input  wire logic               dq_oe,
	input  wire logic               lo_stb_out,
	input  wire logic               up_stb_out
);
	import dpc_pkg::*;
	logic [2:0] cnt_q = 3'h0;
	dpc_data_t  dq_drv = 16'h0000;
	logic       lo_drv = 1'b0;
	logic       up_drv = 1'b0;

	// The link clock runs free, eight system clocks per period.
	always @(negedge mclk) cnt_q <= cnt_q + 3'h1;
	assign ck = cnt_q[2];
	// A shared line shows whichever side has its driver enabled.
	assign dq_w = dq_oe ? dq_out : dq_drv;
	assign lo_stb_w = dq_oe ? lo_stb_out : lo_drv;
	assign up_stb_w = dq_oe ? up_stb_out : up_drv;
	// Idle pins: deselected, clock enabled.
	initial begin
		cke = 1'b1;
		{cs_n, ras_n, cas_n, we_n} = 4'hf;
		ba = 2'h0;
		addr = 13'h0000;
		{upper_byte_mask, lower_byte_mask} = 2'h0;
	end

	// Step to just after a link clock fall, where command pins may change.
	task automatic wait_fall();
		do begin
			@(negedge mclk);
			#1;
		end while (cnt_q !== 3'h0);
	endtask

	// One command held across one link clock rise, then deselect.
	task automatic cmd(input logic [3:0] code, input dpc_bank_t b, input dpc_addr_t a);
		wait_fall();
		{cs_n, ras_n, cas_n, we_n} = code;
		cke = 1'b1;
		ba = b;
		addr = a;
		wait_fall();
		cs_n = 1'b1;
		addr = ~a;
	endtask

	// Data settles one clock before each strobe edge and holds three after.
	task automatic wr_burst(input logic [3:0][15:0] d, input logic [3:0][1:0] m);
		for (int k = 0; k < 4; k++) begin
			dq_drv = d[k];
			{upper_byte_mask, lower_byte_mask} = m[k];
			@(negedge mclk);
			lo_drv = ~lo_drv;
			up_drv = ~up_drv;
			repeat (3) @(negedge mclk);
		end
		// Released lines flip; the stray fifth strobe edge must be ignored.
		dq_drv = ~dq_drv;
		lo_drv = ~lo_drv;
		up_drv = ~up_drv;
		{upper_byte_mask, lower_byte_mask} = ~m[3];
	endtask
endmodule

/* bench/tb_ddr_pin_command_decode.sv */
// Self-checking bench for the pin command decoder.
`timescale 1ns/1ps
`include "dpc_defs.svh"
`define CHECK(got, exp) begin \
	logic [31:0] g_v; \
	logic [31:0] e_v; \
	g_v = (got); \
	e_v = (exp); \
	total_checks++; \
	if (g_v !== e_v) begin \
		bad_count++; \
		$display("ERROR at %0t: got %h expected %h", $time, g_v, e_v); \
	end \
end
module tb_ddr_pin_command_decode;
	import dpc_pkg::*;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        ck, cke, cs_n, ras_n, cas_n, we_n, lbm, ubm, lo_w, up_w;
	logic        dq_oe, lo_out, up_out, lo_oe, up_oe;
	dpc_bank_t   ba;
	dpc_addr_t   addr;
	dpc_data_t   dq_w, dq_out;
	logic [3:0]  bank_active;
	int          bad_count = 0;
	int          total_checks = 0;
	logic [19:0] rd_q [$];
	logic [3:0]  bank_q [$];
	dpc_data_t   mem_m [128];
	logic [1:0]  row_m [4];
	logic [3:0]  open_m = 4'h0;
	logic        prev_lo = 1'b0;
	logic [3:0]  prev_bank = 4'h0;
	logic [2:0]  col;

	// System clock, 25 ns period.
	always #12.5 mclk = ~mclk;

	dpc_ctrl_model m (.mclk(mclk), .ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .lower_byte_mask(lbm),
		.upper_byte_mask(ubm), .dq_w(dq_w), .lo_stb_w(lo_w), .up_stb_w(up_w),
		.dq_out(dq_out), .dq_oe(dq_oe), .lo_stb_out(lo_out), .up_stb_out(up_out));

	dpc_top dut (.mclk(mclk), .rst_n(rst_n), .ck(ck), .cke(cke), .cs_n(cs_n),
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq_w),
		.dq_out(dq_out), .dq_oe(dq_oe), .lower_byte_strobe_in(lo_w),
		.lower_byte_strobe_out(lo_out), .lower_byte_strobe_oe(lo_oe),
		.upper_byte_strobe_in(up_w), .upper_byte_strobe_out(up_out),
		.upper_byte_strobe_oe(up_oe), .lower_byte_mask(lbm), .upper_byte_mask(ubm),
		.bank_active(bank_active));

	// Column address with random unused bits; the auto-precharge bit stays clear.
	function automatic dpc_addr_t col_addr(input logic [2:0] c);
		col_addr = (dpc_addr_t'($urandom) & 13'h1bf8) | {10'h000, c};
	endfunction

	// Open a closed bank on a random row and note the new bank map.
	task automatic open_bank(input dpc_bank_t b);
		dpc_addr_t a;
		a = dpc_addr_t'($urandom);
		row_m[b] = a[1:0];
		open_m[b] = 1'b1;
		bank_q.push_back(open_m);
		m.cmd(`DPC_CMD_ACT, b, a);
	endtask

	// Write four random beats; masked bytes keep their old contents.
	task automatic write_bank(input dpc_bank_t b, input logic [2:0] c, input logic all);
		logic [3:0][15:0] d;
		logic [3:0][1:0]  mk;
		logic [6:0]       key;
		for (int k = 0; k < 4; k++) begin
			d[k] = 16'($urandom);
			mk[k] = all ? 2'h0 : 2'($urandom);
			key = {b, row_m[b], c[2], 2'(c[1:0] + k)};
			if (!mk[k][0]) mem_m[key][7:0] = d[k][7:0];
			if (!mk[k][1]) mem_m[key][15:8] = d[k][15:8];
		end
		m.cmd(`DPC_CMD_WR, b, col_addr(c));
		m.wr_burst(d, mk);
	endtask

	// Read a wrapped burst; beat k carries strobe level ~k[0].
	task automatic read_bank(input dpc_bank_t b, input logic [2:0] c);
		logic [6:0] key;
		for (int k = 0; k < 4; k++) begin
			key = {b, row_m[b], c[2], 2'(c[1:0] + k)};
			rd_q.push_back({2'h3, ~k[0], ~k[0], mem_m[key]});
		end
		m.cmd(`DPC_CMD_RD, b, col_addr(c));
		repeat (4) m.wait_fall();
	endtask

	// Report counts and the verdict, then stop.
	task automatic close_out();
		if (rd_q.size() != 0 || bank_q.size() != 0) begin
			bad_count++;
			$display("ERROR at %0t: %0h results never seen", $time, rd_q.size() + bank_q.size());
		end
		$display("Checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Each read beat or bank map change takes the oldest note.
	always @(negedge mclk) begin
		if (rst_n && dq_oe && lo_out !== prev_lo)
			`CHECK({up_oe, lo_oe, up_out, lo_out, dq_out}, rd_q.size() ? rd_q.pop_front() : 'x)
		if (rst_n && bank_active !== prev_bank)
			`CHECK(bank_active, bank_q.size() ? bank_q.pop_front() : 'x)
		prev_lo = lo_out;
		prev_bank = bank_active;
	end

	// A hang counts as a mismatch.
	initial begin
		repeat (6000) @(posedge mclk);
		bad_count++;
		close_out();
	end

	// Main sequence.
	initial begin
		void'($urandom(64));
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
		repeat (4) @(negedge mclk);
		open_bank(2'h0);
		// Deselected and unlisted codes must leave the bank map alone.
		for (int c = 7; c < 16; c++) m.cmd(4'(c), 2'h1, 13'h0000);
		// A command after a rise with clock enable low is refused.
		m.wait_fall();
		m.cke = 1'b0;
		m.cmd(`DPC_CMD_ACT, 2'h2, 13'h0000);
		// Every bank is opened before it is written or read.
		for (int b = 1; b < 4; b++) open_bank(2'(b));
		for (int b = 0; b < 4; b++) begin
			col = 3'($urandom);
			write_bank(2'(b), col, 1'b1);
			write_bank(2'(b), col, 1'b0);
			read_bank(2'(b), {col[2], 2'($urandom)});
		end
		// Close two banks back to back, then reopen one.
		open_m = 4'he;
		bank_q.push_back(open_m);
		m.cmd(`DPC_CMD_PRE, 2'h0, 13'h0000);
		open_m = 4'h6;
		bank_q.push_back(open_m);
		m.cmd(`DPC_CMD_PRE, 2'h3, 13'h0000);
		repeat (3) m.wait_fall();
		open_bank(2'h0);
		repeat (4) m.wait_fall();
		close_out();
	end
endmodule
